// ==== acm_pkg.sv ====
/*
  constants for the amplifier control and modulator register pair.
  assumes a byte-wide register access port decoded by an upstream serial slave.
*/
// Function
// RULE1: control default follows data strap when bus off
// RULE2: modulator default depends on bus mode
// RULE3: control bit0 selects slow or fast mute
// RULE4: control bit1 enables output offset detection
// RULE5: control bit2 enables pass transistor guard
// RULE6: control bit3 enables step-up converter
// RULE7: control bit4 picks left or right slot
// RULE8: control bit6 selects bass or full band
// RULE9: control bit5 picks 96 or 192 kHz
// RULE10: control bit7 enables converter, default off
// RULE11: modulator bit3 syncs modulator to converter
// RULE12: modulator bit4 starts mid reference charge
// RULE13: modulator bits7:6 pick switching frequency
// RULE14: bit5 tristates modulator, bit0 shunt on
// RULE15: modulator bit2 is gain select high
// RULE16: gain select high default from clock strap; code takes it only with the bus on, bus-off default holds bit 2 at 1
package acm_pkg;
  localparam logic [7:0] ACM_AMP_CONTROL_ADDR     = 8'h04;
  localparam logic [7:0] ACM_MODULATOR_SETUP_ADDR = 8'h05;

  localparam int ACM_MUTE_FAST_BIT     = 0;
  localparam int ACM_OFFSET_DETECT_BIT = 1;
  localparam int ACM_PASS_GUARD_BIT    = 2;
  localparam int ACM_STEP_UP_BIT       = 3;
  localparam int ACM_RIGHT_SLOT_BIT    = 4;
  localparam int ACM_RATE_SELECT_BIT   = 5;
  localparam int ACM_BAND_SELECT_BIT   = 6;
  localparam int ACM_CONV_ENABLE_BIT   = 7;

  localparam int ACM_SHUNT_BIT         = 0;
  localparam int ACM_GAIN_HI_BIT       = 2;
  localparam int ACM_SYNC_BIT          = 3;
  localparam int ACM_MID_REF_BIT       = 4;
  localparam int ACM_TRISTATE_BIT      = 5;
  localparam int ACM_FREQ_LSB          = 6;

  // control defaults; bit 2 is replaced by the data strap when the bus is off
  localparam logic [7:0] ACM_CONTROL_DEFAULT     = 8'h0A;
  localparam logic [7:0] ACM_MOD_DEFAULT_BUS_OFF = 8'h64;
  // bus-on default; bit 2 is replaced by the clock strap
  localparam logic [7:0] ACM_MOD_DEFAULT_BUS_ON  = 8'h41;

  typedef enum logic [1:0] {
    ACM_FREQ_55K   = 2'h0,
    ACM_FREQ_110K  = 2'h1,
    ACM_FREQ_220K  = 2'h2,
    ACM_FREQ_110KB = 2'h3
  } acm_freq_e;

  // one-hot encoded switching frequency selects toward the oscillator
  localparam logic [2:0] ACM_OSC_55K  = 3'h1;
  localparam logic [2:0] ACM_OSC_110K = 3'h2;
  localparam logic [2:0] ACM_OSC_220K = 3'h4;
endpackage

// ==== acm_regs.sv ====
/*
  amplifier control and modulator setup registers with decoded control outputs.
  assumes the serial slave presents a one-cycle write strobe with address and data,
  and holds the straps and bus-enable level steady around reset release.
*/
module acm_regs
  import acm_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       bus_enabled,
  input  wire logic       data_pin_pass_guard_strap,
  input  wire logic       clock_pin_gain_strap,
  input  wire logic       wr_en,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] rd_data,
  output logic            mute_fast,
  output logic            offset_detect_enable,
  output logic            pass_transistor_guard,
  output logic            step_up_enable,
  output logic            right_slot_select,
  output logic            band_select,
  output logic            full_band_rate_select,
  output logic            converter_enable,
  output logic            modulator_dac_sync,
  output logic            mid_reference_charge,
  output logic            modulator_tristate,
  output logic            shunt_on,
  output logic            gain_select_hi,
  output logic      [2:0] switching_freq_select
);
  logic [7:0] amp_control;
  logic [7:0] modulator_setup;
  logic       loaded;
  logic [7:0] next_amp_control;
  logic [7:0] next_modulator_setup;
  logic       next_loaded;
  logic [7:0] next_rd_data;
  logic [2:0] next_freq;
  logic       next_mute_fast;
  logic       next_offset_detect_enable;
  logic       next_pass_transistor_guard;
  logic       next_step_up_enable;
  logic       next_right_slot_select;
  logic       next_band_select;
  logic       next_full_band_rate_select;
  logic       next_converter_enable;
  logic       next_modulator_dac_sync;
  logic       next_mid_reference_charge;
  logic       next_modulator_tristate;
  logic       next_shunt_on;
  logic       next_gain_select_hi;

  always_comb begin
    next_amp_control     = amp_control;
    next_modulator_setup = modulator_setup;
    next_loaded          = 1'b1;
    if (!loaded) begin
      // RULE1: strap-dependent control default
      next_amp_control = ACM_CONTROL_DEFAULT;
      next_amp_control[ACM_PASS_GUARD_BIT] = bus_enabled ? 1'b0 : data_pin_pass_guard_strap;
      // RULE2: mode-dependent modulator default
      if (bus_enabled) begin
        next_modulator_setup = ACM_MOD_DEFAULT_BUS_ON;
        // RULE16: gain default from clock strap
        next_modulator_setup[ACM_GAIN_HI_BIT] = clock_pin_gain_strap;
      end else begin
        next_modulator_setup = ACM_MOD_DEFAULT_BUS_OFF;
      end
    end else if (wr_en && bus_enabled) begin
      if (addr == ACM_AMP_CONTROL_ADDR) begin
        next_amp_control = wr_data;
      end
      if (addr == ACM_MODULATOR_SETUP_ADDR) begin
        next_modulator_setup = wr_data;
        // RULE15: bit 1 unused, stays zero
        next_modulator_setup[1] = 1'b0;
      end
    end
    if (addr == ACM_AMP_CONTROL_ADDR) begin
      next_rd_data = next_amp_control;
    end else if (addr == ACM_MODULATOR_SETUP_ADDR) begin
      next_rd_data = next_modulator_setup;
    end else begin
      next_rd_data = 8'h00;
    end
  end

  // RULE13: 11 aliases to 110 kHz
  always_comb begin
    unique case (acm_freq_e'(next_modulator_setup[ACM_FREQ_LSB +: 2]))
      ACM_FREQ_55K:   next_freq = ACM_OSC_55K;
      ACM_FREQ_110K:  next_freq = ACM_OSC_110K;
      ACM_FREQ_220K:  next_freq = ACM_OSC_220K;
      ACM_FREQ_110KB: next_freq = ACM_OSC_110K;
    endcase
  end

  // decoded outputs take the next register image so they move on the same edge as the write
  always_comb begin
    // RULE3: mute speed
    next_mute_fast             = next_amp_control[ACM_MUTE_FAST_BIT];
    // RULE4: offset detection
    next_offset_detect_enable  = next_amp_control[ACM_OFFSET_DETECT_BIT];
    // RULE5: pass guard
    next_pass_transistor_guard = next_amp_control[ACM_PASS_GUARD_BIT];
    // RULE6: step-up enable
    next_step_up_enable        = next_amp_control[ACM_STEP_UP_BIT];
    // RULE7: slot select
    next_right_slot_select     = next_amp_control[ACM_RIGHT_SLOT_BIT];
    // RULE8: band select
    next_band_select           = next_amp_control[ACM_BAND_SELECT_BIT];
    // RULE9: rate only meaningful in full band
    next_full_band_rate_select = next_amp_control[ACM_BAND_SELECT_BIT] & next_amp_control[ACM_RATE_SELECT_BIT];
    // RULE10: converter enable
    next_converter_enable      = next_amp_control[ACM_CONV_ENABLE_BIT];
    // RULE11: modulator sync
    next_modulator_dac_sync    = next_modulator_setup[ACM_SYNC_BIT];
    // RULE12: mid reference charge
    next_mid_reference_charge  = next_modulator_setup[ACM_MID_REF_BIT];
    // RULE14: tristate and shunt
    next_modulator_tristate    = next_modulator_setup[ACM_TRISTATE_BIT];
    next_shunt_on              = next_modulator_setup[ACM_SHUNT_BIT];
    // RULE15: gain select high
    next_gain_select_hi        = next_modulator_setup[ACM_GAIN_HI_BIT];
  end

  // defaults load on the first edge after release so straps are sampled, not reset into flops
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      amp_control           <= 8'h00;
      modulator_setup       <= 8'h00;
      loaded                <= 1'b0;
      rd_data               <= 8'h00;
      mute_fast             <= 1'b0;
      offset_detect_enable  <= 1'b0;
      pass_transistor_guard <= 1'b0;
      step_up_enable        <= 1'b0;
      right_slot_select     <= 1'b0;
      band_select           <= 1'b0;
      full_band_rate_select <= 1'b0;
      converter_enable      <= 1'b0;
      modulator_dac_sync    <= 1'b0;
      mid_reference_charge  <= 1'b0;
      modulator_tristate    <= 1'b0;
      shunt_on              <= 1'b0;
      gain_select_hi        <= 1'b0;
      switching_freq_select <= ACM_OSC_55K;
    end else begin
      amp_control           <= next_amp_control;
      modulator_setup       <= next_modulator_setup;
      loaded                <= next_loaded;
      rd_data               <= next_rd_data;
      mute_fast             <= next_mute_fast;
      offset_detect_enable  <= next_offset_detect_enable;
      pass_transistor_guard <= next_pass_transistor_guard;
      step_up_enable        <= next_step_up_enable;
      right_slot_select     <= next_right_slot_select;
      band_select           <= next_band_select;
      full_band_rate_select <= next_full_band_rate_select;
      converter_enable      <= next_converter_enable;
      modulator_dac_sync    <= next_modulator_dac_sync;
      mid_reference_charge  <= next_mid_reference_charge;
      modulator_tristate    <= next_modulator_tristate;
      shunt_on              <= next_shunt_on;
      gain_select_hi        <= next_gain_select_hi;
      switching_freq_select <= next_freq;
    end
  end

  // sampled rstn keeps the release edge, where the flops still sit in reset, out of the default checks
  // RULE1: bus-off control default tracks strap
  a_ctrl_default_strap: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE1
    rstn && !loaded && !bus_enabled |=>
    amp_control == (ACM_CONTROL_DEFAULT | {5'h00, $past(data_pin_pass_guard_strap), 2'h0}))
    else $error("control default wrong with bus off");
  // RULE1: bus-on control default ignores strap
  a_ctrl_default_on: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE1
    rstn && !loaded && bus_enabled |=>
    amp_control == ACM_CONTROL_DEFAULT && !pass_transistor_guard)
    else $error("control default wrong with bus on");
  // RULE2: modulator bus-off default
  a_mod_default_off: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE2
    rstn && !loaded && !bus_enabled |=>
    modulator_setup == ACM_MOD_DEFAULT_BUS_OFF)
    else $error("modulator default wrong with bus off");
  // RULE2: modulator bus-on default
  a_mod_default_on: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE2
    rstn && !loaded && bus_enabled |=>
    modulator_setup == (ACM_MOD_DEFAULT_BUS_ON | {5'h00, $past(clock_pin_gain_strap), 2'h0}))
    else $error("modulator default wrong with bus on");
  // RULE16: gain default from clock strap
  a_gain_default_strap: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE16
    rstn && !loaded && bus_enabled |=>
    gain_select_hi == $past(clock_pin_gain_strap) && modulator_setup[ACM_SHUNT_BIT])
    else $error("gain default not from strap");
  // RULE3: mute output follows written bit
  a_mute_write: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE3
    loaded && wr_en && bus_enabled && addr == ACM_AMP_CONTROL_ADDR |=>
    mute_fast == $past(wr_data[ACM_MUTE_FAST_BIT]) && amp_control == $past(wr_data))
    else $error("mute speed not written");
  // RULE3: slow mute after power-up
  a_mute_default_slow: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE3
    rstn && !loaded |=>
    !mute_fast)
    else $error("mute speed default not slow");
  // RULE4: offset detect written
  a_offset_write: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE4
    loaded && wr_en && bus_enabled && addr == ACM_AMP_CONTROL_ADDR |=>
    offset_detect_enable == $past(wr_data[ACM_OFFSET_DETECT_BIT]))
    else $error("offset detect not written");
  // RULE5: pass guard written
  a_pass_guard_write: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE5
    loaded && wr_en && bus_enabled && addr == ACM_AMP_CONTROL_ADDR |=>
    pass_transistor_guard == $past(wr_data[ACM_PASS_GUARD_BIT]))
    else $error("pass guard not written");
  // RULE6: step-up written
  a_step_up_write: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE6
    loaded && wr_en && bus_enabled && addr == ACM_AMP_CONTROL_ADDR |=>
    step_up_enable == $past(wr_data[ACM_STEP_UP_BIT]))
    else $error("step-up enable not written");
  // RULE7: slot select written
  a_slot_write: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE7
    loaded && wr_en && bus_enabled && addr == ACM_AMP_CONTROL_ADDR |=>
    right_slot_select == $past(wr_data[ACM_RIGHT_SLOT_BIT]))
    else $error("slot select not written");
  // RULE8: band select written
  a_band_write: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE8
    loaded && wr_en && bus_enabled && addr == ACM_AMP_CONTROL_ADDR |=>
    band_select == $past(wr_data[ACM_BAND_SELECT_BIT]))
    else $error("band select not written");
  // RULE9: rate follows write in full band
  a_rate_write: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE9
    loaded && wr_en && bus_enabled && addr == ACM_AMP_CONTROL_ADDR |=>
    full_band_rate_select == ($past(wr_data[ACM_BAND_SELECT_BIT]) && $past(wr_data[ACM_RATE_SELECT_BIT])))
    else $error("rate select not written");
  // RULE9: rate select masked in bass band
  a_rate_masked: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE9
    full_band_rate_select |->
    band_select && amp_control[ACM_RATE_SELECT_BIT])
    else $error("rate select active in bass band");
  // RULE10: converter off after default load
  a_conv_default_off: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE10
    rstn && !loaded |=>
    !converter_enable && step_up_enable && offset_detect_enable)
    else $error("control default enables wrong");
  // RULE10: converter enable written
  a_conv_write: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE10
    loaded && wr_en && bus_enabled && addr == ACM_AMP_CONTROL_ADDR |=>
    converter_enable == $past(wr_data[ACM_CONV_ENABLE_BIT]))
    else $error("converter enable not written");
  // RULE11: sync bit written
  a_sync_write: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE11
    loaded && wr_en && bus_enabled && addr == ACM_MODULATOR_SETUP_ADDR |=>
    modulator_dac_sync == $past(wr_data[ACM_SYNC_BIT]))
    else $error("sync bit not written");
  // RULE11: sync and reference off by default
  a_sync_default_off: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE11
    rstn && !loaded |=>
    !modulator_dac_sync && !mid_reference_charge)
    else $error("sync or reference default on");
  // RULE12: mid reference follows register
  a_mid_ref: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE12
    loaded |->
    mid_reference_charge == modulator_setup[ACM_MID_REF_BIT] && modulator_dac_sync == modulator_setup[ACM_SYNC_BIT])
    else $error("sync or reference bit mismatch");
  // RULE12: mid reference written
  a_mid_ref_write: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE12
    loaded && wr_en && bus_enabled && addr == ACM_MODULATOR_SETUP_ADDR |=>
    mid_reference_charge == $past(wr_data[ACM_MID_REF_BIT]))
    else $error("reference charge not written");
  // RULE13: frequency decode of alias code
  a_freq_decode: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE13
    loaded && modulator_setup[ACM_FREQ_LSB +: 2] == 2'h3 |->
    switching_freq_select == ACM_OSC_110K)
    else $error("alias code not middle frequency");
  // RULE13: lowest frequency code
  a_freq_low: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE13
    loaded && wr_en && bus_enabled && addr == ACM_MODULATOR_SETUP_ADDR && wr_data[ACM_FREQ_LSB +: 2] == 2'h0 |=>
    switching_freq_select == ACM_OSC_55K)
    else $error("low frequency code wrong");
  // RULE13: highest frequency code
  a_freq_high: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE13
    loaded && wr_en && bus_enabled && addr == ACM_MODULATOR_SETUP_ADDR && wr_data[ACM_FREQ_LSB +: 2] == 2'h2 |=>
    switching_freq_select == ACM_OSC_220K)
    else $error("high frequency code wrong");
  // RULE13: middle frequency after power-up
  a_freq_default: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE13
    rstn && !loaded |=>
    switching_freq_select == ACM_OSC_110K)
    else $error("frequency default wrong");
  // RULE14: tristate and shunt track register
  a_tristate_shunt: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE14
    loaded && wr_en && bus_enabled && addr == ACM_MODULATOR_SETUP_ADDR |=>
    modulator_tristate == $past(wr_data[ACM_TRISTATE_BIT]) && shunt_on == $past(wr_data[ACM_SHUNT_BIT]))
    else $error("modulator bits not written");
  // RULE14: bus-off default tristates modulator
  a_tristate_default: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE14
    rstn && !loaded && !bus_enabled |=>
    modulator_tristate && !shunt_on)
    else $error("tristate default wrong with bus off");
  // RULE15: gain select written
  a_gain_write: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE15
    loaded && wr_en && bus_enabled && addr == ACM_MODULATOR_SETUP_ADDR |=>
    gain_select_hi == $past(wr_data[ACM_GAIN_HI_BIT]))
    else $error("gain select not written");
  // RULE15: unused modulator bit stays clear
  a_unused_bit: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE15
    loaded |->
    !modulator_setup[1])
    else $error("unused modulator bit set");
  // RULE15: modulator read back
  a_rd_mod: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE15
    loaded && addr == ACM_MODULATOR_SETUP_ADDR |=>
    rd_data == modulator_setup)
    else $error("modulator read data wrong");
endmodule

// ==== acm_host_model.sv ====
/*
  serial slave stand-in that presents the register access strobe.
  assumes it is clocked by the bench clock; requests change just after a rising edge.
*/
module acm_host_model (
  input  wire logic       sys_clk,
  output logic            wr_en,
  output logic      [7:0] addr,
  output logic      [7:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    wr_en = 1'h0;
    addr = 8'h04;
    wr_data = 8'h00;
  end
  // one request per edge, so back to back strobes never toggle within one step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    wr_en <= w;
    addr <= a;
    wr_data <= d;
  endtask
endmodule

// ==== tb_amp_control_modulator_regs.sv ====
/*
  self-checking bench for the control and modulator register pair.
  assumes acm_pkg and acm_regs are compiled first; the host model drives the strobe.
*/
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; $display("BAD %0t mismatch got %h exp %h", $time, a, b); end end
module tb_amp_control_modulator_regs
  import acm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk, rstn, be, ds, cs, armed, wr_en;
  logic [7:0]  addr, wr_data, rd_data, ctl, mod, exp_rd;
  wire  [15:0] outs;
  logic [31:0] r;
  integer      seed, error_cnt, tests_run, cyc;
  int          k;
  acm_host_model u_host (.sys_clk(sys_clk), .wr_en(wr_en), .addr(addr), .wr_data(wr_data));
  acm_regs u_dut (.sys_clk(sys_clk), .rstn(rstn), .bus_enabled(be), .data_pin_pass_guard_strap(ds),
    .clock_pin_gain_strap(cs), .wr_en(wr_en), .addr(addr), .wr_data(wr_data), .rd_data(rd_data),
    .mute_fast(outs[15]), .offset_detect_enable(outs[14]), .pass_transistor_guard(outs[13]),
    .step_up_enable(outs[12]), .right_slot_select(outs[11]), .band_select(outs[10]),
    .full_band_rate_select(outs[9]), .converter_enable(outs[8]), .modulator_dac_sync(outs[7]),
    .mid_reference_charge(outs[6]), .modulator_tristate(outs[5]), .shunt_on(outs[4]),
    .gain_select_hi(outs[3]), .switching_freq_select(outs[2:0]));
  always #25 sys_clk = ~sys_clk;
  function automatic logic [15:0] dec(logic [7:0] c, logic [7:0] m);
    logic [2:0] f;
    f = (m[7:6] == 2'h0) ? 3'h1 : (m[7:6] == 2'h2) ? 3'h4 : 3'h2;
    return {c[0], c[1], c[2], c[3], c[4], c[6], c[6] & c[5], c[7], m[3], m[4], m[5], m[0], m[2], f};
  endfunction
  task give_verdict;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      give_verdict;
    end
  end
  // refused writes leave the model untouched; modulator bit 1 never stores
  task step(input logic w, input logic [7:0] a, input logic [7:0] d);
    u_host.xfer(w, a, d);
    #1;
    if (armed) begin
      `CHK(rd_data, exp_rd)
      `CHK(outs, dec(ctl, mod))
    end
    if (w && be && a == ACM_AMP_CONTROL_ADDR) ctl = d;
    if (w && be && a == ACM_MODULATOR_SETUP_ADDR) mod = d & 8'hFD;
    exp_rd = (a == ACM_AMP_CONTROL_ADDR) ? ctl : (a == ACM_MODULATOR_SETUP_ADDR) ? mod : 8'h00;
    armed = 1'h1;
  endtask
  task do_reset(input logic b, input logic dsv, input logic csv);
    armed = 1'h0;
    u_host.xfer(1'h0, ACM_AMP_CONTROL_ADDR, 8'h00);
    rstn <= 1'h0;
    be <= b;
    ds <= dsv;
    cs <= csv;
    repeat (11) @(posedge sys_clk);
    #1;
    `CHK(outs, 16'h0001)
    @(posedge sys_clk);
    rstn <= 1'h1;
    @(posedge sys_clk);
    // straps only count in their own bus mode
    ctl = ACM_CONTROL_DEFAULT | {5'h00, ~b & dsv, 2'h0};
    mod = b ? (ACM_MOD_DEFAULT_BUS_ON | {5'h00, csv, 2'h0}) : ACM_MOD_DEFAULT_BUS_OFF;
  endtask
  initial begin
    seed = 32'h2549;
    error_cnt = 0;
    tests_run = 0;
    cyc = 0;
    sys_clk = 1'h0;
    rstn = 1'h0;
    be = 1'h0;
    ds = 1'h0;
    cs = 1'h0;
    armed = 1'h0;
    for (k = 0; k < 4; k++) begin
      do_reset(~k[0], ~k[1], ~(k[0] ^ k[1]));
      step(1'h0, ACM_AMP_CONTROL_ADDR, 8'h00);
      step(1'h0, ACM_MODULATOR_SETUP_ADDR, 8'h00);
      step(1'h1, ACM_MODULATOR_SETUP_ADDR, 8'hFF);
      step(1'h1, ACM_AMP_CONTROL_ADDR, 8'hFF);
      step(1'h1, 8'h06, 8'h5A);
      repeat (150) begin
        r = $random(seed);
        step(r[0] | r[1], (r[3:2] == 2'h3) ? r[23:16] : {7'h02, r[2]}, r[15:8]);
      end
    end
    give_verdict;
  end
endmodule
